//--- inc/vid_pkg.sv
`default_nettype none
package vid_pkg;
  // ***********************
  // Port addresses
  // ***********************
  localparam logic [15:0] PORT_MISC_WR = 16'h03C2;
  localparam logic [15:0] PORT_MISC_RD = 16'h03CC;
  localparam logic [15:0] PORT_STAT0 = 16'h03C2;
  localparam logic [15:0] PORT_SUBSYS = 16'h03C3;
  localparam logic [15:0] PORT_SEQ_IDX = 16'h03C4;
  localparam logic [15:0] PORT_SEQ_DAT = 16'h03C5;
  localparam logic [15:0] PORT_FEAT_RD = 16'h03CA;
  localparam logic [15:0] PORT_STAT1_MONO = 16'h03BA;
  localparam logic [15:0] PORT_STAT1_COLOR = 16'h03DA;
  localparam logic [11:0] CRT_BASE_MONO = 12'h03B;
  localparam logic [11:0] CRT_BASE_COLOR = 12'h03D;
  localparam logic [3:0] CRT_IDX_LOW = 4'h4;
  localparam logic [3:0] CRT_DAT_LOW = 4'h5;
  // ***********************
  // Sequencer indexes
  // ***********************
  localparam logic [2:0] SEQ_RESET = 3'h0;
  localparam logic [2:0] SEQ_CLOCKING = 3'h1;
  localparam logic [2:0] SEQ_PLANE_MASK = 3'h2;
  localparam logic [2:0] SEQ_CHAR_MAP = 3'h3;
  localparam logic [2:0] SEQ_MEM_MODE = 3'h4;
  // ***********************
  // Field positions
  // ***********************
  localparam int MISC_VSP = 7;
  localparam int MISC_HSP = 6;
  localparam int MISC_CS_HI = 3;
  localparam int MISC_CS_LO = 2;
  localparam int MISC_DECODE = 1;
  localparam int MISC_PORT_BASE = 0;
  localparam int STAT0_IRQ = 7;
  localparam int STAT0_SENSE = 4;
  localparam int STAT1_VR = 3;
  localparam int STAT1_DE_N = 0;
  localparam int RST_SYNC = 1;
  localparam int RST_ASYNC = 0;
  localparam int CLK_SCREEN_OFF = 5;
  localparam int CLK_LOAD4 = 4;
  localparam int CLK_HALF_DOT = 3;
  localparam int CLK_LOAD2 = 2;
  localparam int CLK_FIXED_ONE = 1;
  localparam int CLK_NARROW = 0;
  // ***********************
  // Reset values and codes
  // ***********************
  localparam logic [7:0] MISC_RESET = 8'h00;
  localparam logic [7:0] SEQ_RESET_VAL = 8'h03;
  localparam logic [7:0] CLOCKING_RESET = 8'h02;
  localparam logic [7:0] MASK_RESET = 8'h0F;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [1:0] CLKSEL_25 = 2'b00;
  localparam logic [1:0] CLKSEL_28 = 2'b01;
  localparam logic [1:0] CLKSEL_EXT = 2'b10;
  localparam logic [9:0] LINES_400 = 10'd400;
  localparam logic [9:0] LINES_350 = 10'd350;
  localparam logic [9:0] LINES_480 = 10'd480;
  localparam logic [3:0] DOTS_WIDE = 4'd9;
  localparam logic [3:0] DOTS_NARROW = 4'd8;
  localparam logic [7:0] LINE_CODE_LO = 8'hC0;
  localparam logic [7:0] LINE_CODE_HI = 8'hDF;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } io_req_t;

  typedef struct packed {
    logic req;
    logic we;
    logic in_buffer;
  } mem_req_t;
endpackage : vid_pkg
`default_nettype wire

//--- src/vid_general_seq.sv
// Contract
// - Misc output written 03C2, read 03CC
// - Bit 7 sets vertical retrace polarity
// - Bit 6 sets horizontal retrace polarity
// - Polarity bits encode 400/350/480 vertical size
// - Clock select picks 25, 28 or external
// - Decode bit off: ignore display buffer accesses
// - Port base bit moves CRT, status1, feature
// - Status 0: irq pending bit7, sense bit4
// - Status1 bit 3 shows vertical retrace
// - Status1 bit 0 is inverted display enable
// - Feature control decoded, all bits reserved
// - Index at 03C4 steers data port 03C5
// - Sequencer registers 00 to 04 read/write
// - Sync clear bit low halts sequencer
// - Async clear bit low halts immediately
// - Screen off blanks, keeps sync, frees bandwidth
// - Serializer load every 1, 2 or 4 chars
// - Half dot rate divides master clock
// - Character clock 9 or 8 dots wide
// - Ninth dot repeats eighth for C0-DF
// - Plane mask gates host plane writes
`default_nettype none
module vid_general_seq (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire vid_pkg::io_req_t io_req,
  output logic [7:0] io_rdata,
  output logic io_ack,
  output logic io_hit,
  output logic crt_index_sel,
  output logic crt_data_sel,
  input wire vid_pkg::mem_req_t mem_req,
  output logic [3:0] plane_we,
  output logic mem_ack,
  output logic host_priority,
  input wire logic tick_25,
  input wire logic tick_28,
  input wire logic tick_ext,
  input wire logic hretrace_raw,
  input wire logic vretrace_raw,
  input wire logic display_enable,
  input wire logic retrace_irq_pending,
  input wire logic monitor_sense,
  input wire logic [7:0] char_code,
  input wire logic [7:0] glyph_bits,
  output logic hsync_out,
  output logic vsync_out,
  output logic [9:0] vertical_lines,
  output logic dot_tick,
  output logic char_tick,
  output logic serializer_load,
  output logic pixel_out,
  output logic seq_running
);
  // ***********************
  // Register state
  // ***********************
  logic [7:0] misc_output_control_q, sequencer_reset_q, clocking_mode_q, plane_write_mask_q;
  logic [7:0] char_map_q, mem_mode_q;
  logic [2:0] sequencer_index_q;
  logic vertical_sync_polarity, horizontal_sync_polarity, buffer_decode_on, port_base_choice;
  logic sync_clear_n, async_clear_n, load_every_four, half_dot_rate, load_every_two;
  logic narrow_char_cell, screen_off;
  logic [1:0] clk_choice;
  logic [11:0] crt_base;
  logic [15:0] stat1_port;
  logic wr_misc, wr_idx, wr_dat, wr_feat;
  assign vertical_sync_polarity = misc_output_control_q[vid_pkg::MISC_VSP];
  assign horizontal_sync_polarity = misc_output_control_q[vid_pkg::MISC_HSP];
  assign clk_choice = misc_output_control_q[vid_pkg::MISC_CS_HI:vid_pkg::MISC_CS_LO];
  assign buffer_decode_on = misc_output_control_q[vid_pkg::MISC_DECODE];
  assign port_base_choice = misc_output_control_q[vid_pkg::MISC_PORT_BASE];
  assign sync_clear_n = sequencer_reset_q[vid_pkg::RST_SYNC];
  assign async_clear_n = sequencer_reset_q[vid_pkg::RST_ASYNC];
  assign screen_off = clocking_mode_q[vid_pkg::CLK_SCREEN_OFF];
  assign load_every_four = clocking_mode_q[vid_pkg::CLK_LOAD4];
  assign half_dot_rate = clocking_mode_q[vid_pkg::CLK_HALF_DOT];
  assign load_every_two = clocking_mode_q[vid_pkg::CLK_LOAD2];
  assign narrow_char_cell = clocking_mode_q[vid_pkg::CLK_NARROW];
  // ***********************
  // Port decode
  // ***********************
  // The monochrome and colour bases are mutually exclusive, so a stray access to
  // the unselected base is simply not ours and gets no hit.
  assign crt_base = port_base_choice ? vid_pkg::CRT_BASE_COLOR : vid_pkg::CRT_BASE_MONO;
  assign stat1_port = port_base_choice ? vid_pkg::PORT_STAT1_COLOR
                                       : vid_pkg::PORT_STAT1_MONO;
  assign wr_misc = io_req.wr && io_req.addr == vid_pkg::PORT_MISC_WR;
  assign wr_idx = io_req.wr && io_req.addr == vid_pkg::PORT_SEQ_IDX;
  assign wr_dat = io_req.wr && io_req.addr == vid_pkg::PORT_SEQ_DAT;
  assign wr_feat = io_req.wr && io_req.addr == stat1_port;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      misc_output_control_q <= vid_pkg::MISC_RESET;
    end else if (wr_misc) begin
      misc_output_control_q <= io_req.wdata;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sequencer_index_q <= 3'h0;
    end else if (wr_idx) begin
      sequencer_index_q <= io_req.wdata[2:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sequencer_reset_q <= vid_pkg::SEQ_RESET_VAL;
      clocking_mode_q <= vid_pkg::CLOCKING_RESET;
      plane_write_mask_q <= vid_pkg::MASK_RESET;
      char_map_q <= vid_pkg::ZERO_BYTE;
      mem_mode_q <= vid_pkg::ZERO_BYTE;
    end else if (wr_dat) begin
      case (sequencer_index_q)
        vid_pkg::SEQ_RESET: sequencer_reset_q <= io_req.wdata;
        vid_pkg::SEQ_CLOCKING: clocking_mode_q <= io_req.wdata;
        vid_pkg::SEQ_PLANE_MASK: plane_write_mask_q <= io_req.wdata;
        vid_pkg::SEQ_CHAR_MAP: char_map_q <= io_req.wdata;
        vid_pkg::SEQ_MEM_MODE: mem_mode_q <= io_req.wdata;
        default: ; // Indexes 5-7 absorb writes harmlessly
      endcase
    end
  end

  // ***********************
  // Read path
  // ***********************
  logic [7:0] seq_rd, rd_d;
  logic hit_d;
  always_comb begin
    case (sequencer_index_q)
      vid_pkg::SEQ_RESET: seq_rd = sequencer_reset_q;
      vid_pkg::SEQ_CLOCKING: seq_rd = clocking_mode_q;
      vid_pkg::SEQ_PLANE_MASK: seq_rd = plane_write_mask_q;
      vid_pkg::SEQ_CHAR_MAP: seq_rd = char_map_q;
      vid_pkg::SEQ_MEM_MODE: seq_rd = mem_mode_q;
      default: seq_rd = vid_pkg::ZERO_BYTE;
    endcase
  end
  always_comb begin
    rd_d = vid_pkg::ZERO_BYTE;
    hit_d = 1'b1;
    if (io_req.addr == vid_pkg::PORT_MISC_RD) begin
      rd_d = misc_output_control_q;
    end else if (io_req.addr == vid_pkg::PORT_STAT0) begin
      rd_d[vid_pkg::STAT0_IRQ] = retrace_irq_pending;
      rd_d[vid_pkg::STAT0_SENSE] = monitor_sense;
    end else if (io_req.addr == stat1_port) begin
      rd_d[vid_pkg::STAT1_VR] = vretrace_raw;
      rd_d[vid_pkg::STAT1_DE_N] = ~display_enable;
    end else if (io_req.addr == vid_pkg::PORT_FEAT_RD) begin
      rd_d = vid_pkg::ZERO_BYTE;
    end else if (io_req.addr == vid_pkg::PORT_SEQ_IDX) begin
      rd_d = {5'h00, sequencer_index_q};
    end else if (io_req.addr == vid_pkg::PORT_SEQ_DAT) begin
      rd_d = seq_rd;
    end else if (io_req.addr == vid_pkg::PORT_SUBSYS) begin
      rd_d = vid_pkg::ZERO_BYTE;
    end else begin
      hit_d = (io_req.addr[15:4] == crt_base) &&
              (io_req.addr[3:0] == vid_pkg::CRT_IDX_LOW ||
               io_req.addr[3:0] == vid_pkg::CRT_DAT_LOW);
    end
  end

  // Writes to the status-1/feature port and to 03C3 hit but store nothing; a write to 03C2 stores the misc register
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      io_rdata <= vid_pkg::ZERO_BYTE;
      io_ack <= 1'b0;
      io_hit <= 1'b0;
      crt_index_sel <= 1'b0;
      crt_data_sel <= 1'b0;
    end else begin
      io_ack <= io_req.rd || io_req.wr;
      io_hit <= (io_req.rd && hit_d) || wr_misc || wr_idx || wr_dat || wr_feat ||
                (io_req.wr && io_req.addr == vid_pkg::PORT_SUBSYS) ||
                (io_req.wr && hit_d && io_req.addr[15:4] == crt_base);
      io_rdata <= io_req.rd ? rd_d : vid_pkg::ZERO_BYTE;
      crt_index_sel <= (io_req.rd || io_req.wr) && io_req.addr[15:4] == crt_base &&
                       io_req.addr[3:0] == vid_pkg::CRT_IDX_LOW;
      crt_data_sel <= (io_req.rd || io_req.wr) && io_req.addr[15:4] == crt_base &&
                      io_req.addr[3:0] == vid_pkg::CRT_DAT_LOW;
    end
  end

  // ***********************
  // Host memory path
  // ***********************
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      plane_we <= 4'h0;
      mem_ack <= 1'b0;
      host_priority <= 1'b0;
    end else begin
      mem_ack <= mem_req.req && mem_req.in_buffer && buffer_decode_on;
      plane_we <= (mem_req.req && mem_req.we && mem_req.in_buffer && buffer_decode_on)
                  ? plane_write_mask_q[3:0] : 4'h0;
      host_priority <= screen_off;
    end
  end

  // ***********************
  // Sync polarity and size
  // ***********************
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      hsync_out <= 1'b0;
      vsync_out <= 1'b0;
      vertical_lines <= 10'd0;
    end else begin
      vsync_out <= vretrace_raw ^ vertical_sync_polarity;
      hsync_out <= hretrace_raw ^ horizontal_sync_polarity;
      case ({vertical_sync_polarity, horizontal_sync_polarity})
        2'b01: vertical_lines <= vid_pkg::LINES_400;
        2'b10: vertical_lines <= vid_pkg::LINES_350;
        2'b11: vertical_lines <= vid_pkg::LINES_480;
        default: vertical_lines <= 10'd0;
      endcase
    end
  end

  // ***********************
  // Dot and character timing
  // ***********************
  // Both clear bits gate the counters combinationally through run, so either halts the
  // sequencer in the same cycle; under sync clear only half_q waits for a tick to clear.
  logic master_tick, run, dot_en, char_en;
  logic half_q;
  logic [3:0] dot_cnt_q;
  logic [1:0] char_cnt_q;
  logic [3:0] last_dot;
  always_comb begin
    case (clk_choice)
      vid_pkg::CLKSEL_25: master_tick = tick_25;
      vid_pkg::CLKSEL_28: master_tick = tick_28;
      vid_pkg::CLKSEL_EXT: master_tick = tick_ext;
      default: master_tick = 1'b0;
    endcase
  end
  assign run = sync_clear_n && async_clear_n;
  assign dot_en = run && master_tick && (!half_dot_rate || half_q);
  assign last_dot = (narrow_char_cell ? vid_pkg::DOTS_NARROW : vid_pkg::DOTS_WIDE) - 4'd1;
  assign char_en = dot_en && dot_cnt_q >= last_dot;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      half_q <= 1'b0;
    end else if (!async_clear_n) begin
      half_q <= 1'b0;
    end else if (master_tick) begin
      half_q <= sync_clear_n ? ~half_q : 1'b0;
    end
  end
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      dot_cnt_q <= 4'd0;
    end else if (!run) begin
      dot_cnt_q <= 4'd0;
    end else if (dot_en) begin
      dot_cnt_q <= char_en ? 4'd0 : dot_cnt_q + 4'd1;
    end
  end
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      char_cnt_q <= 2'd0;
    end else if (!run) begin
      char_cnt_q <= 2'd0;
    end else if (char_en) begin
      char_cnt_q <= char_cnt_q + 2'd1;
    end
  end
  logic load_d;
  always_comb begin
    if (load_every_four) begin
      load_d = char_en && char_cnt_q == 2'd3;
    end else if (load_every_two) begin
      load_d = char_en && char_cnt_q[0];
    end else begin
      load_d = char_en;
    end
  end
  logic glyph_bit, line_code;
  assign line_code = char_code >= vid_pkg::LINE_CODE_LO && char_code <= vid_pkg::LINE_CODE_HI;
  assign glyph_bit = (dot_cnt_q[3]) ? (line_code && glyph_bits[0])
                                    : glyph_bits[3'd7 - dot_cnt_q[2:0]];
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      dot_tick <= 1'b0;
      char_tick <= 1'b0;
      serializer_load <= 1'b0;
      pixel_out <= 1'b0;
      seq_running <= 1'b0;
    end else begin
      dot_tick <= dot_en;
      char_tick <= char_en;
      serializer_load <= load_d;
      seq_running <= run;
      if (dot_en) begin
        pixel_out <= glyph_bit && display_enable && !screen_off;
      end else if (!run) begin
        pixel_out <= 1'b0;
      end
    end
  end

  // ***********************
  // Checks
  // ***********************
  property p_misc_store;
    @(posedge ref_clk) disable iff (!rst_b)
    wr_misc |=> misc_output_control_q == $past(io_req.wdata);
  endproperty
  a_misc_store: assert property (p_misc_store) else $error("misc write lost");
  // A polarity write lands with the edge, so only cycles without one are judged
  property p_vsync_pol;
    @(posedge ref_clk) disable iff (!rst_b)
    !wr_misc |=> vsync_out == ($past(vretrace_raw) ^ vertical_sync_polarity);
  endproperty
  a_vsync_pol: assert property (p_vsync_pol) else $error("vsync polarity wrong");
  property p_hsync_pol;
    @(posedge ref_clk) disable iff (!rst_b)
    !wr_misc |=> hsync_out == ($past(hretrace_raw) ^ horizontal_sync_polarity);
  endproperty
  a_hsync_pol: assert property (p_hsync_pol) else $error("hsync polarity wrong");
  property p_no_decode;
    @(posedge ref_clk) disable iff (!rst_b)
    !buffer_decode_on && $stable(misc_output_control_q) |=> !mem_ack && plane_we == 4'h0;
  endproperty
  a_no_decode: assert property (p_no_decode) else $error("buffer answered while off");
  property p_stat1_read;
    @(posedge ref_clk) disable iff (!rst_b)
    io_req.rd && io_req.addr == stat1_port |=>
      io_rdata[vid_pkg::STAT1_DE_N] == !$past(display_enable) &&
      io_rdata[vid_pkg::STAT1_VR] == $past(vretrace_raw);
  endproperty
  a_stat1_read: assert property (p_stat1_read) else $error("status1 read wrong");
  property p_halt;
    @(posedge ref_clk) disable iff (!rst_b)
    !run |-> !dot_en ##1 (dot_cnt_q == 4'd0 && !dot_tick);
  endproperty
  a_halt: assert property (p_halt) else $error("sequencer ran while cleared");
  property p_char_width;
    @(posedge ref_clk) disable iff (!rst_b)
    dot_en && !narrow_char_cell |-> dot_cnt_q <= vid_pkg::DOTS_WIDE - 4'd1;
  endproperty
  a_char_width: assert property (p_char_width) else $error("dot count past cell");
  property p_half_rate;
    @(posedge ref_clk) disable iff (!rst_b)
    half_dot_rate && dot_en && !wr_dat |=> !dot_en;
  endproperty
  a_half_rate: assert property (p_half_rate) else $error("half rate dot doubled");
  property p_plane_mask;
    @(posedge ref_clk) disable iff (!rst_b)
    mem_req.req && mem_req.we && mem_req.in_buffer && buffer_decode_on && !wr_dat
      |=> plane_we == plane_write_mask_q[3:0];
  endproperty
  a_plane_mask: assert property (p_plane_mask) else $error("plane enables wrong");
  property p_blank;
    @(posedge ref_clk) disable iff (!rst_b)
    screen_off && dot_en && !wr_dat |=> !pixel_out;
  endproperty
  a_blank: assert property (p_blank) else $error("pixel lit with screen off");
endmodule : vid_general_seq
`default_nettype wire

//--- bench/vid_host.sv
`default_nettype none
module vid_host (
  input wire logic ref_clk,
  output var vid_pkg::io_req_t io_req,
  output var vid_pkg::mem_req_t mem_req,
  input wire logic [7:0] io_rdata,
  input wire logic io_ack,
  input wire logic io_hit,
  input wire logic [3:0] plane_we,
  input wire logic mem_ack
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    io_req = '0;
    mem_req = '0;
  end

  // One port cycle; answers stand one cycle, so they are taken at the next falling edge.
  // A released bus shows inverted address and data, never the stale values.
  task automatic access(input logic rd, input logic [15:0] addr, input logic [7:0] wdata,
                        output logic [7:0] rdata, output logic hit, output logic ack);
    @(negedge ref_clk);
    io_req <= '{rd: rd, wr: !rd, addr: addr, wdata: wdata};
    @(negedge ref_clk);
    rdata = io_rdata;
    hit = io_hit;
    ack = io_ack;
    io_req <= '{rd: 1'b0, wr: 1'b0, addr: ~addr, wdata: ~wdata};
  endtask : access

  task automatic mem_write(output logic [3:0] we, output logic ack);
    @(negedge ref_clk);
    mem_req <= '{req: 1'b1, we: 1'b1, in_buffer: 1'b1};
    @(negedge ref_clk);
    we = plane_we;
    ack = mem_ack;
    mem_req <= '0;
  endtask : mem_write
endmodule : vid_host
`default_nettype wire

//--- bench/tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  vid_pkg::io_req_t io_req;
  vid_pkg::mem_req_t mem_req;
  logic [7:0] io_rdata, d;
  logic io_ack, io_hit, crt_index_sel, crt_data_sel, mem_ack, host_priority, hit, ack;
  logic [3:0] plane_we, we;
  logic tick_25 = 1'b1, tick_28 = 1'b0, tick_ext = 1'b0;
  logic hretrace_raw = 1'b1, vretrace_raw = 1'b0, display_enable = 1'b1;
  logic retrace_irq_pending = 1'b0, monitor_sense = 1'b0;
  logic [7:0] char_code = 8'h00, glyph_bits = 8'h01;
  logic hsync_out, vsync_out, dot_tick, char_tick, serializer_load, pixel_out, seq_running;
  logic [9:0] vertical_lines;
  logic [3:0] probe;
  logic [15:0] cycles = 16'h0000;
  int num_errors = 0;
  int checked = 0;
  int n;

  assign probe = {pixel_out, serializer_load, char_tick, dot_tick};
  always #5 ref_clk = ~ref_clk;

  vid_general_seq i_dut (
    .ref_clk, .rst_b, .io_req, .io_rdata, .io_ack, .io_hit, .crt_index_sel, .crt_data_sel,
    .mem_req, .plane_we, .mem_ack, .host_priority, .tick_25, .tick_28, .tick_ext,
    .hretrace_raw, .vretrace_raw, .display_enable, .retrace_irq_pending, .monitor_sense,
    .char_code, .glyph_bits, .hsync_out, .vsync_out, .vertical_lines, .dot_tick,
    .char_tick, .serializer_load, .pixel_out, .seq_running
  );
  vid_host i_host (
    .ref_clk, .io_req, .mem_req, .io_rdata, .io_ack, .io_hit, .plane_we, .mem_ack
  );

  // Master enables at full, half and quarter rate so each clock choice is told apart
  always @(negedge ref_clk) begin
    cycles <= cycles + 16'h0001;
    tick_28 <= cycles[0];
    tick_ext <= (cycles[1:0] == 2'b00);
    if (cycles == 16'h4e20) begin
      num_errors++;
      results();
    end
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [15:0] addr, input logic [7:0] data);
    i_host.access(1'b0, addr, data, d, hit, ack);
  endtask : wr

  task automatic rd(input logic [15:0] addr);
    i_host.access(1'b1, addr, 8'h00, d, hit, ack);
    chk("read ack", 16'h0001, 16'(ack));
  endtask : rd

  task automatic seq_wr(input logic [2:0] idx, input logic [7:0] data);
    wr(16'h03c4, {5'h00, idx});
    wr(16'h03c5, data);
  endtask : seq_wr

  task automatic setup(input logic [7:0] misc, input logic [7:0] clk_mode);
    seq_wr(3'h0, 8'h01);
    wr(16'h03c2, misc);
    seq_wr(3'h1, clk_mode);
    seq_wr(3'h0, 8'h03);
  endtask : setup

  // Window of 288 cycles is a multiple of every expected period, so counts are exact
  task automatic count(input int sel);
    n = 0;
    repeat (40) @(negedge ref_clk);
    repeat (288) begin
      @(negedge ref_clk);
      n += int'(probe[sel] === 1'b1);
    end
  endtask : count

  task automatic t_regs();
    logic [7:0] exp [8] = '{8'h03, 8'h02, 8'h0f, 8'h00, 8'h00, 8'h05, 8'h2d, 8'h0a};
    rd(16'h03cc);
    chk("misc reset", 16'h0000, 16'(d));
    for (int i = 0; i < 8; i++) begin
      if (i > 4) seq_wr(3'(i - 3), exp[i]);
      if (i < 5) wr(16'h03c4, 8'(i));
      rd(16'h03c5);
      chk("seq data", 16'(exp[i]), 16'(d));
    end
    seq_wr(3'h5, 8'hff);
    rd(16'h03c5);
    chk("reserved index", 16'h0000, 16'(d));
    chk("running", 16'h0001, 16'(seq_running));
    $display("test registers done");
  endtask : t_regs

  task automatic t_misc();
    logic [9:0] lines [4] = '{10'h000, 10'h190, 10'h15e, 10'h1e0};
    for (int i = 0; i < 4; i++) begin
      wr(16'h03c2, {2'(i), 6'h02});
      rd(16'h03cc);
      chk("misc data", 16'({2'(i), 6'h02}), 16'(d));
      chk("vertical size", 16'(lines[i]), 16'(vertical_lines));
      chk("hsync", 16'(hretrace_raw ^ i[0]), 16'(hsync_out));
      chk("vsync", 16'(vretrace_raw ^ i[1]), 16'(vsync_out));
    end
    $display("test misc done");
  endtask : t_misc

  task automatic t_ports();
    logic [15:0] sel;
    for (int b = 0; b < 2; b++) begin
      vretrace_raw = !b[0];
      display_enable = b[0];
      retrace_irq_pending = !b[0];
      monitor_sense = !b[0];
      wr(16'h03c2, {7'h01, b[0]});
      sel = b[0] ? 16'h03da : 16'h03ba;
      rd(sel);
      chk("status1 hit", 16'h0001, 16'(hit));
      chk("status1 bits", {12'h000, !b[0], 2'b00, !b[0]}, 16'(d & 8'h09));
      rd(b[0] ? 16'h03ba : 16'h03da);
      chk("status1 other base", 16'h0000, 16'(hit));
      rd(b[0] ? 16'h03d4 : 16'h03b4);
      chk("crt index", 16'h0001, 16'(crt_index_sel));
      wr(b[0] ? 16'h03d5 : 16'h03b5, 8'h00);
      chk("crt data", 16'h0001, 16'(crt_data_sel));
      wr(sel, 8'hff);
      chk("feature write", 16'h0001, 16'(hit));
      rd(16'h03c2);
      chk("status0 bits", {8'h00, !b[0], 2'b00, !b[0], 4'h0}, 16'(d & 8'h90));
    end
    rd(16'h03ca);
    chk("feature read", 16'h0100, {7'h00, hit, d});
    rd(16'h0300);
    chk("unmapped", 16'h0000, {7'h00, hit, d});
    $display("test ports done");
  endtask : t_ports

  task automatic t_mem();
    logic [3:0] mask [3] = '{4'h5, 4'hf, 4'hf};
    for (int i = 0; i < 3; i++) begin
      wr(16'h03c2, {6'h00, i < 2, 1'b0});
      seq_wr(3'h2, {4'h0, mask[i]});
      i_host.mem_write(we, ack);
      chk("plane enables", 16'(i < 2 ? mask[i] : 4'h0), 16'(we));
      chk("buffer ack", 16'(i < 2), 16'(ack));
    end
    $display("test memory done");
  endtask : t_mem

  task automatic t_run();
    logic [7:0] val [4] = '{8'h01, 8'h02, 8'h00, 8'h03};
    for (int i = 0; i < 4; i++) begin
      seq_wr(3'h0, val[i]);
      count(1);
      chk("running", 16'(i == 3), 16'(seq_running));
      chk("char ticks", i == 3 ? 16'h0020 : 16'h0000, 16'(n));
    end
    $display("test sequencer reset done");
  endtask : t_run

  task automatic t_clock();
    logic [31:0] row [11] = '{32'h0202_0120, 32'h0203_0124, 32'h0603_0112, 32'h0a03_0109,
      32'h0e03_0000, 32'h020b_0090, 32'h020b_0112, 32'h0203_0224, 32'h0207_0212,
      32'h0213_0209, 32'h0217_0209};
    for (int i = 0; i < 11; i++) begin
      setup(row[i][31:24], row[i][23:16]);
      count(int'(row[i][15:8]));
      chk("tick count", 16'(row[i][7:0]), 16'(n));
    end
    $display("test clocking done");
  endtask : t_clock

  task automatic t_pixel();
    logic [23:0] row [5] = '{24'hc0_0240, 24'hdf_0240, 24'hbf_0220, 24'he0_0220,
      24'hc0_2200};
    for (int i = 0; i < 5; i++) begin
      char_code = row[i][23:16];
      setup(8'h02, row[i][15:8]);
      count(3);
      chk("lit dots", 16'(row[i][7:0]), 16'(n));
      chk("host priority", 16'(row[i][13]), 16'(host_priority));
      chk("sync kept", 16'(hretrace_raw), 16'(hsync_out));
    end
    $display("test pixel done");
  endtask : t_pixel

  task automatic results();
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : results

  initial begin
    repeat (2) @(negedge ref_clk);
    rst_b = 1'b1;
    t_regs();
    t_misc();
    t_ports();
    t_mem();
    t_run();
    t_clock();
    t_pixel();
    results();
  end
endmodule : tb
`default_nettype wire
